// file: sbsc_defs.svh
// sbsc_defs.svh - constants of the burst sram control port
`ifndef SBSC_DEFS_SVH
`define SBSC_DEFS_SVH

`define SBSC_ADDR_W     19
`define SBSC_LANES      4
`define SBSC_BYTE_W     8
`define SBSC_DATA_W     32
`define SBSC_WORD_W     36
`define SBSC_STORE_AW   4
`define SBSC_STORE_D    16
`define SBSC_CNT_W      2
`define SBSC_SYNC_W     3
`define SBSC_SYNC_RST   3'h5
`define SBSC_SYNC_OE    0
`define SBSC_SYNC_SLEEP 1
`define SBSC_SYNC_MODE  2
`define SBSC_CNT_RST    2'h0
`define SBSC_CNT_STEP   2'h1

`endif

// file: sbsc_pkg.sv
// sbsc_pkg.sv - types of the burst sram control port
package sbsc_pkg;

    // kind of data phase that follows the last qualified edge
    typedef enum logic [1:0]
    {
        SBSC_DESEL,
        SBSC_READ,
        SBSC_WRITE
    } sbsc_phase_t;

endpackage

// file: sbsc_port.sv
// sbsc_port.sv - synchronous control port of a flow-through burst sram
//
// Functional notes
// - address taken at edge selects location
// - low two address bits load burst counter
// - byte lane writes active low, need write
// - write strobe sampled only on qualified edge
// - advance high increments burst counter
// - advance low loads new access
// - unqualified edges ignored, state held
// - three selects decide selection
// - output enable low allows driving
// - drivers off: write, emerging, deselected
// - read data one edge later, flow-through
// - strap picks linear or interleaved order
// - qualify high stalls, does not deselect
// - sleep input holds contents, low power
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_defs.svh"

// ****************************************
// two flip-flop synchroniser
// ****************************************
module sbsc_sync2
#(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input  wire logic         mclk_i,   // clock
    input  wire logic         rst_b_i,  // sync reset, active low
    input  wire logic [W-1:0] async_i,  // asynchronous levels
    output logic      [W-1:0] sync_o    // synchronised levels
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb
    begin
        next_meta = rst_b_i ? async_i : RST;
        next_sync = rst_b_i ? meta : RST;
    end

    always_ff @(posedge mclk_i)
    begin
        meta   <= next_meta;
        sync_o <= next_sync;
    end
endmodule

// ****************************************
// write merge of one byte lane
// ****************************************
module sbsc_lane_merge
#(
    parameter int W = `SBSC_BYTE_W
)
(
    input  wire logic         en_i,      // lane written this edge
    input  wire logic [W-1:0] new_i,     // incoming byte
    input  wire logic         new_par_i, // incoming parity bit
    input  wire logic [W-1:0] old_i,     // stored byte
    input  wire logic         old_par_i, // stored parity bit
    output logic      [W-1:0] byte_o,    // merged byte
    output logic              par_o      // merged parity bit
);
    // a disabled lane keeps its stored byte and parity
    assign byte_o = en_i ? new_i : old_i;
    assign par_o  = en_i ? new_par_i : old_par_i;
endmodule

// ****************************************
// control port
// ****************************************
module sbsc_port
    import sbsc_pkg::*;
(
    input  wire logic                      mclk_i,          // 20 MHz clock
    input  wire logic                      rst_b_i,         // sync reset
    input  wire logic [`SBSC_ADDR_W-1:0]   addr_i,          // address
    input  wire logic [`SBSC_LANES-1:0]    byte_lane_write_n_i, // lanes
    input  wire logic                      write_n_i,       // write strobe
    input  wire logic                      advance_or_load_i, // adv / load
    input  wire logic                      clock_qualify_n_i, // qualify
    input  wire logic                      select_one_n_i,  // select 1
    input  wire logic                      select_two_i,    // select 2
    input  wire logic                      select_three_n_i, // select 3
    input  wire logic                      output_enable_n_i, // async oe
    input  wire logic                      burst_mode_i,    // order strap
    input  wire logic                      sleep_request_i, // async sleep
    input  wire logic [`SBSC_DATA_W-1:0]   data_i,          // write data
    input  wire logic [`SBSC_LANES-1:0]    parity_lines_i,  // write parity
    output logic      [`SBSC_DATA_W-1:0]   data_o,          // read data
    output logic      [`SBSC_LANES-1:0]    parity_lines_o,  // read parity
    output logic                           data_oe_o        // drive enable
);

    // ****************************************
    // asynchronous inputs
    // ****************************************
    logic [`SBSC_SYNC_W-1:0] sync_lvl;
    logic                    oe_n_s;
    logic                    asleep;
    logic                    linear;

    // strap, sleep and oe share one two-flop stage
    sbsc_sync2
    #(
        .W   (`SBSC_SYNC_W),
        .RST (`SBSC_SYNC_RST)
    )
    u_sync
    (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .async_i ({burst_mode_i, sleep_request_i, output_enable_n_i}),
        .sync_o  (sync_lvl)
    );

    assign oe_n_s = sync_lvl[`SBSC_SYNC_OE];
    assign asleep = sync_lvl[`SBSC_SYNC_SLEEP];
    // strap low means linear order, high or open interleaved
    assign linear = ~sync_lvl[`SBSC_SYNC_MODE];

    // ****************************************
    // access state
    // ****************************************
    sbsc_phase_t                   phase;
    sbsc_phase_t                   next_phase;
    logic [`SBSC_ADDR_W-1:0]       base;
    logic [`SBSC_ADDR_W-1:0]       next_base;
    logic [`SBSC_CNT_W-1:0]        cnt;
    logic [`SBSC_CNT_W-1:0]        next_cnt;
    logic [`SBSC_LANES-1:0]        lanes;
    logic [`SBSC_LANES-1:0]        next_lanes;
    logic                          emerge;
    logic                          next_emerge;
    logic [`SBSC_WORD_W-1:0]       rd_word;
    logic [`SBSC_WORD_W-1:0]       next_rd_word;
    logic [`SBSC_WORD_W-1:0]       mem [`SBSC_STORE_D];
    logic [`SBSC_WORD_W-1:0]       next_mem [`SBSC_STORE_D];

    logic                          qual;
    logic                          selected;
    logic                          wr_now;
    logic [`SBSC_CNT_W-1:0]        low;
    logic [`SBSC_CNT_W-1:0]        next_low;
    logic [`SBSC_STORE_AW-1:0]     cur_idx;
    logic [`SBSC_STORE_AW-1:0]     next_idx;
    logic [`SBSC_WORD_W-1:0]       wr_in;
    wire  [`SBSC_WORD_W-1:0]       wr_word;
    logic [`SBSC_WORD_W-1:0]       old_word;

    // edges only count while qualify is low; sleep freezes too
    assign qual     = ~clock_qualify_n_i & ~asleep;
    assign selected = ~select_one_n_i & select_two_i
                    & ~select_three_n_i;

    // burst address: wraps in four either way
    always_comb
    begin
        if (linear)
        begin
            low      = base[`SBSC_CNT_W-1:0] + cnt;
            next_low = next_base[`SBSC_CNT_W-1:0] + next_cnt;
        end
        else
        begin
            low      = base[`SBSC_CNT_W-1:0] ^ cnt;
            next_low = next_base[`SBSC_CNT_W-1:0] ^ next_cnt;
        end
    end

    assign cur_idx  = {base[`SBSC_STORE_AW-1:`SBSC_CNT_W], low};
    assign next_idx = {next_base[`SBSC_STORE_AW-1:`SBSC_CNT_W], next_low};

    // command decode on a qualified edge
    always_comb
    begin
        next_phase  = phase;
        next_base   = base;
        next_cnt    = cnt;
        next_lanes  = lanes;
        next_emerge = emerge;
        if (!rst_b_i)
        begin
            next_phase  = SBSC_DESEL;
            next_base   = '0;
            next_cnt    = `SBSC_CNT_RST;
            next_lanes  = '0;
            next_emerge = 1'b0;
        end
        else if (qual)
        begin
            next_emerge = 1'b0;
            if (advance_or_load_i)
            begin
                // advancing while deselected stays deselected
                if (phase != SBSC_DESEL)
                begin
                    next_cnt   = cnt + `SBSC_CNT_STEP;
                    next_lanes = ~byte_lane_write_n_i;
                end
            end
            else if (selected)
            begin
                next_phase  = write_n_i ? SBSC_READ
                                        : SBSC_WRITE;
                next_base   = addr_i;
                next_cnt    = `SBSC_CNT_RST;
                next_lanes  = ~byte_lane_write_n_i;
                next_emerge = (phase == SBSC_DESEL);
            end
            else
            begin
                next_phase = SBSC_DESEL;
            end
        end
    end

    // ****************************************
    // storage and data path
    // ****************************************
    assign wr_in  = {parity_lines_i, data_i};
    // write data of the current phase lands on this qualified edge
    assign wr_now = rst_b_i & qual & (phase == SBSC_WRITE);

    // one merge per lane, parity rides with its byte
    assign old_word = mem[cur_idx];

    for (genvar k = 0; k < `SBSC_LANES; k++)
    begin : g_lane
        sbsc_lane_merge
        #(
            .W (`SBSC_BYTE_W)
        )
        u_lane
        (
            .en_i      (lanes[k]),
            .new_i     (wr_in[k*`SBSC_BYTE_W +: `SBSC_BYTE_W]),
            .new_par_i (wr_in[`SBSC_DATA_W + k]),
            .old_i     (old_word[k*`SBSC_BYTE_W +: `SBSC_BYTE_W]),
            .old_par_i (old_word[`SBSC_DATA_W + k]),
            .byte_o    (wr_word[k*`SBSC_BYTE_W +: `SBSC_BYTE_W]),
            .par_o     (wr_word[`SBSC_DATA_W + k])
        );
    end

    // read word for the next phase, with the write of this edge
    // forwarded so back-to-back write then read sees new data
    always_comb
    begin
        next_rd_word = rd_word;
        if (!rst_b_i)
            next_rd_word = '0;
        else if (qual)
        begin
            if (wr_now && (next_idx == cur_idx))
                next_rd_word = wr_word;
            else
                next_rd_word = mem[next_idx];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        phase   <= next_phase;
        base    <= next_base;
        cnt     <= next_cnt;
        lanes   <= next_lanes;
        emerge  <= next_emerge;
        rd_word <= next_rd_word;
    end

    // contents have no reset and survive sleep
    always_comb
    begin
        next_mem = mem;
        if (wr_now)
            next_mem[cur_idx] = wr_word;
    end

    always_ff @(posedge mclk_i)
    begin
        mem <= next_mem;
    end

    // ****************************************
    // output drivers
    // ****************************************
    assign data_o         = rd_word[`SBSC_DATA_W-1:0];
    assign parity_lines_o = rd_word[`SBSC_WORD_W-1:`SBSC_DATA_W];
    // oe is synchronised, so the enable follows the pin two clocks late
    assign data_oe_o      = (phase == SBSC_READ) & ~emerge
                          & ~oe_n_s & ~asleep;

endmodule
`default_nettype wire

// file: sbsc_port_asserts.sv
// sbsc_port_asserts.sv - pin-level checks of the sram control port
`timescale 1ns/1ps
`default_nettype none
module sbsc_port_chk
(
    input wire logic        mclk_i,            // clock
    input wire logic        rst_b_i,           // sync reset
    input wire logic        write_n_i,         // write strobe
    input wire logic        advance_or_load_i, // adv / load
    input wire logic        clock_qualify_n_i, // qualify
    input wire logic        select_one_n_i,    // select 1
    input wire logic        select_two_i,      // select 2
    input wire logic        select_three_n_i,  // select 3
    input wire logic        output_enable_n_i, // oe
    input wire logic        sleep_request_i,   // sleep
    input wire logic [31:0] data_o,            // read data
    input wire logic [3:0]  parity_lines_o,    // read parity
    input wire logic        data_oe_o          // drive enable
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i || sleep_request_i);
    logic sel;
    logic ld;
    assign sel = !select_one_n_i && select_two_i && !select_three_n_i;
    assign ld = !clock_qualify_n_i && !advance_or_load_i;
    property p_wr_off; ld && !write_n_i |=> !data_oe_o; endproperty
    a_wr_off: assert property (p_wr_off) else $error("drive in write");
    property p_desel; ld && !sel |=> !data_oe_o; endproperty
    a_desel: assert property (p_desel) else $error("drive deselected");
    property p_emerge; ld && !sel ##1 ld && sel |=> !data_oe_o; endproperty
    a_emerge: assert property (p_emerge) else $error("drive emerging");
    property p_oe_hi; output_enable_n_i [*3] |-> !data_oe_o; endproperty
    a_oe_hi: assert property (p_oe_hi) else $error("drive with oe high");
    sequence s_rd;
        ld && sel && write_n_i && !output_enable_n_i;
    endsequence
    property p_rd_on; s_rd ##1 s_rd |=> data_oe_o; endproperty
    a_rd_on: assert property (p_rd_on) else $error("read not driven");
    property p_stall;
        clock_qualify_n_i |=> $stable(data_o) && $stable(parity_lines_o);
    endproperty
    a_stall: assert property (p_stall) else $error("stall moved data");
    property p_adv_off;
        ld && !sel ##1 !clock_qualify_n_i && advance_or_load_i |=> !data_oe_o;
    endproperty
    a_adv_off: assert property (p_adv_off) else $error("advance selected");
    property p_rst; $rose(rst_b_i) |-> !data_oe_o && data_o == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    c_rd: cover property (s_rd ##1 data_oe_o);
    c_stall: cover property (clock_qualify_n_i ##1 !clock_qualify_n_i);
    c_emerge: cover property (ld && !sel ##1 ld && sel);
endmodule
bind sbsc_port sbsc_port_chk u_chk (.mclk_i, .rst_b_i, .write_n_i,
    .advance_or_load_i, .clock_qualify_n_i, .select_one_n_i, .select_two_i,
    .select_three_n_i, .output_enable_n_i, .sleep_request_i, .data_o,
    .parity_lines_o, .data_oe_o);
`default_nettype wire

// file: sbsc_bus_master.sv
// sbsc_bus_master.sv - bus master model for the sram control port
`timescale 1ns/1ps
`default_nettype none
module sbsc_bus_master
(
    input  wire logic        mclk_i,    // clock
    output logic      [18:0] addr_o,    // address
    output logic      [3:0]  lanes_n_o, // byte lane writes
    output logic      [5:0]  ctl_o,     // adv, write_n, qual_n, selects
    output logic      [35:0] wdata_o    // parity and data
);
    logic        pend = 1'b0;
    logic [35:0] nxt = 36'h0;
    initial
    begin
        addr_o = 19'h0;
        lanes_n_o = 4'hF;
        ctl_o = 6'h18;
        wdata_o = 36'h0;
    end
    // write data trails its command by one qualified edge
    task automatic beat(input logic [27:0] c, input logic wph,
                        input logic [35:0] wd);
        @(posedge mclk_i);
        #2;
        {ctl_o[5:4], ctl_o[2:0], addr_o, lanes_n_o} = c;
        ctl_o[3] = 1'b0;
        // bus not owed any data shows no stale copy
        wdata_o = pend ? nxt : ~wdata_o;
        pend = wph;
        nxt = wd;
    endtask
    // junk on an ignored edge; pending write data must survive it
    task automatic stall(input logic [27:0] junk);
        @(posedge mclk_i);
        #2;
        {ctl_o[5:4], ctl_o[2:0], addr_o, lanes_n_o} = junk;
        ctl_o[3] = 1'b1;
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// tb.sv - self-checking bench for the sram control port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sbsc_pkg::*;
    localparam logic [2:0] SEL = 3'h2;
    logic        mclk_i = 1'b0, rst_b_i = 1'b0, oe_n = 1'b0, mode = 1'b0;
    logic        pend = 1'b0, took = 1'b0, slp = 1'b0, drv;
    logic [18:0] addr;
    logic [3:0]  lanes_n, par, base, idx, pidx, pln;
    logic [5:0]  ctl;
    logic [35:0] wdata, wd, got;
    logic [31:0] rdata;
    logic [1:0]  n = 2'h0;
    logic [35:0] mem [16];
    logic [35:0] exp_q [$];
    logic [2:0]  dsel [3] = '{3'h6, 3'h0, 3'h3};
    sbsc_phase_t ph = SBSC_DESEL, nph;
    integer      seed = 66163, failures = 0, checks_done = 0, i, k, r, m;
    initial forever #25 mclk_i = ~mclk_i;
    sbsc_port uut (.mclk_i, .rst_b_i, .addr_i(addr),
        .byte_lane_write_n_i(lanes_n), .write_n_i(ctl[4]),
        .advance_or_load_i(ctl[5]), .clock_qualify_n_i(ctl[3]),
        .select_one_n_i(ctl[2]), .select_two_i(ctl[1]),
        .select_three_n_i(ctl[0]), .output_enable_n_i(oe_n),
        .burst_mode_i(mode), .sleep_request_i(slp), .data_i(wdata[31:0]),
        .parity_lines_i(wdata[35:32]), .data_o(rdata),
        .parity_lines_o(par), .data_oe_o(drv));
    sbsc_bus_master u_m (.mclk_i, .addr_o(addr), .lanes_n_o(lanes_n),
        .ctl_o(ctl), .wdata_o(wdata));
    task automatic err(input string s);
        failures++;
        $display("[ERR] %0t %s", $time, s);
    endtask
    task automatic conclude();
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic op(input logic a, w_n, input logic [2:0] s,
                      input logic [18:0] ad, input logic [3:0] ln);
        logic [35:0] w;
        w = {4'($random(seed)), 32'($random(seed))};
        for (k = 0; k < 4; k++)
            if (pend && !pln[k])
                {mem[pidx][32+k], mem[pidx][8*k+:8]} = {wd[32+k], wd[8*k+:8]};
        if (!a)
        begin
            base = ad[3:0];
            n = 2'h0;
            nph = s != SEL ? SBSC_DESEL : w_n ? SBSC_READ : SBSC_WRITE;
        end
        else
        begin
            n = n + 2'h1;
            nph = ph;
        end
        idx = {base[3:2], mode ? base[1:0] ^ n : base[1:0] + n};
        if (nph == SBSC_READ && ph != SBSC_DESEL && !oe_n)
            exp_q.push_back(mem[idx]);
        pend = nph == SBSC_WRITE;
        {pidx, pln, wd} = {idx, ln, w};
        u_m.beat({a, w_n, s, ad, ln}, pend, w);
        ph = nph;
    endtask
    task automatic idle3();
        repeat (3) op(1'b0, 1'b1, 3'h0, 19'h0, 4'hF);
    endtask
    always @(posedge mclk_i)
    begin
        if (took && drv !== 1'b0 && drv !== 1'b1)
            err("drive enable unknown");
        if (took && drv === 1'b1)
        begin
            checks_done++;
            got = {par, rdata};
            if (exp_q.size() == 0 || exp_q[0] !== got)
                err("read data or drive wrong");
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
        took <= !ctl[3] && rst_b_i;
    end
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        err("run too long");
        conclude();
    end
    initial
    begin
        repeat (2) @(posedge mclk_i);
        #2;
        rst_b_i = 1'b1;
        idle3();
        for (i = 0; i < 16; i++)
            op(i % 4 != 0, 1'b0, SEL, 19'(i), 4'h0);
        for (m = 0; m < 2; m++)
        begin
            mode = m[0];
            idle3();
            for (i = 0; i < 300; i++)
            begin
                r = $random(seed);
                if (r[3:0] == 4'h0)
                    u_m.stall(28'(r));
                op(r[4] && ph != SBSC_DESEL, r[5],
                   r[8:6] == 3'h0 ? dsel[r[10:9] % 3] : SEL,
                   19'($random(seed)), r[14:11]);
            end
        end
        // sleep parks a read burst, drops the drivers, ignores a write
        op(1'b0, 1'b1, SEL, 19'h1, 4'hF);
        op(1'b1, 1'b1, SEL, 19'h0, 4'hF);
        slp = 1'b1;
        repeat (3) u_m.stall(28'h0);
        u_m.beat({2'h0, SEL, 19'h0, 4'h0}, 1'b0, 36'h0);
        u_m.stall(28'h0);
        checks_done++;
        if (drv !== 1'b0)
            err("drive while asleep");
        slp = 1'b0;
        repeat (3) u_m.stall(28'h0);
        op(1'b0, 1'b1, SEL, 19'h0, 4'hF);
        idle3();
        // advance while deselected must not start an access
        op(1'b1, 1'b1, SEL, 19'h0, 4'hF);
        op(1'b0, 1'b1, SEL, 19'h5, 4'hF);
        op(1'b1, 1'b1, SEL, 19'h0, 4'hF);
        oe_n = 1'b1;
        idle3();
        for (i = 0; i < 8; i++)
            op(i != 0, 1'b1, SEL, 19'h2, 4'hF);
        oe_n = 1'b0;
        idle3();
        repeat (3) @(posedge mclk_i);
        if (exp_q.size() != 0)
            err("reads left undriven");
        conclude();
    end
endmodule
`default_nettype wire
